/* nnei_host.sv */
// Host controller model that drives the register port of the unit.
`timescale 1ns/100ps
module nnei_host (
    // Clock.
    input  wire logic        mclk,
    // Register port.
    output logic      [3:0]  reg_addr,
    output logic      [15:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata
);
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // The write data is inverted once the strobe drops, so a stale value cannot pass.
    task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;
    endtask : write_reg

    task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : read_reg
endmodule : nnei_host

/* nnei_pkg.sv */
// Package of constants for the network node error indicator.
package nnei_pkg;
    // Node address range that the unit accepts.
    localparam logic [7:0]  NODE_MIN        = 8'h01;
    localparam logic [7:0]  NODE_MAX        = 8'h3e;
    // Status word bit positions.
    localparam int          ST_CTRL_BIT     = 1;
    localparam int          ST_ADDR_BIT     = 8;
    localparam int          ST_DUP_BIT      = 9;
    localparam int          ST_LOG_BIT      = 15;
    // Error log codes.
    localparam logic [15:0] CODE_CTRL       = 16'h0210;
    localparam logic [15:0] CODE_DUP        = 16'h0211;
    localparam logic [15:0] CODE_ADDR       = 16'h0214;
    // Log depth.
    localparam int          LOG_DEPTH       = 39;
    localparam int          LOG_AW          = 6;
    // Register offsets.
    localparam logic [3:0]  REG_STATUS      = 4'h0;
    localparam logic [3:0]  REG_IRQ_STATUS  = 4'h1;
    localparam logic [3:0]  REG_IRQ_MASK    = 4'h2;
    localparam logic [3:0]  REG_LOG_COUNT   = 4'h3;
    localparam logic [3:0]  REG_LOG_INDEX   = 4'h4;
    localparam logic [3:0]  REG_LOG_DATA    = 4'h5;
    localparam logic [3:0]  REG_LOG_CLEAR   = 4'h6;
    localparam logic [3:0]  REG_NODE        = 4'h7;
    // Reset values.
    localparam logic [15:0] STATUS_RST      = 16'h0000;
    localparam logic [2:0]  IRQ_MASK_RST    = 3'h0;
    // Interrupt bit positions.
    localparam int          IRQ_ADDR        = 0;
    localparam int          IRQ_CTRL        = 1;
    localparam int          IRQ_DUP         = 2;
endpackage : nnei_pkg

/* nnei_top.sv */
// Indicator, status word and error log logic of a network node unit.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module nnei_top
    import nnei_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Node condition inputs from pins and link logic.
    input  wire logic [7:0]  node_addr,
    input  wire logic        ctrl_fault,
    input  wire logic        dup_addr,
    input  wire logic        fiber_miswire,
    input  wire logic        in_network,
    input  wire logic        host_fault,
    // Register port.
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Front panel indicators and interrupt.
    output logic             run_indicator,
    output logic             comm_error_indicator,
    output logic             host_error_indicator,
    output logic             in_network_indicator,
    output logic             irq
);

    function automatic logic addr_bad(input logic [7:0] a);
        addr_bad = (a < NODE_MIN) || (a > NODE_MAX);
    endfunction : addr_bad

    // Pin inputs pass two flip-flops before use.
    logic [7:0]  addr_s1;
    logic [7:0]  addr_s2;
    logic [4:0]  cond_s1;
    logic [4:0]  cond_s2;

    // The address stages reset to a legal address. A zero here would look like an
    // address error and log a false event in the cycles just after reset.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            addr_s1 <= NODE_MIN;
            addr_s2 <= NODE_MIN;
            cond_s1 <= 5'h00;
            cond_s2 <= 5'h00;
        end else begin
            addr_s1 <= node_addr;
            addr_s2 <= addr_s1;
            cond_s1 <= {host_fault, in_network, fiber_miswire, dup_addr, ctrl_fault};
            cond_s2 <= cond_s1;
        end
    end

    logic err_addr;
    logic err_ctrl;
    logic err_dup;
    assign err_addr = addr_bad(addr_s2);
    assign err_ctrl = cond_s2[0];
    assign err_dup  = cond_s2[1] | cond_s2[2];

    // Error events fire on the rising edge of each condition, so a persistent
    // fault logs once rather than flooding the log.
    logic       addr_q;
    logic       ctrl_q;
    logic       dup_q;
    logic       ev_addr;
    logic       ev_ctrl;
    logic       ev_dup;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            addr_q <= 1'b0;
            ctrl_q <= 1'b0;
            dup_q  <= 1'b0;
        end else begin
            addr_q <= err_addr;
            ctrl_q <= err_ctrl;
            dup_q  <= err_dup;
        end
    end

    assign ev_addr = err_addr & ~addr_q;
    assign ev_ctrl = err_ctrl & ~ctrl_q;
    assign ev_dup  = err_dup & ~dup_q;

    // Indicators; an address error outranks the others because the unit
    // never joins the network with an illegal address.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            run_indicator        <= 1'b0;
            comm_error_indicator <= 1'b0;
            host_error_indicator <= 1'b0;
            in_network_indicator <= 1'b0;
        end else if (err_addr) begin
            run_indicator        <= 1'b0;
            comm_error_indicator <= 1'b1;
            host_error_indicator <= 1'b0;
            in_network_indicator <= 1'b0;
        end else if (err_ctrl) begin
            run_indicator        <= 1'b0;
            comm_error_indicator <= 1'b1;
            host_error_indicator <= 1'b0;
            in_network_indicator <= 1'b0;
        end else if (err_dup) begin
            run_indicator        <= 1'b1;
            comm_error_indicator <= 1'b1;
            host_error_indicator <= 1'b0;
            in_network_indicator <= 1'b0;
        end else begin
            run_indicator        <= 1'b1;
            comm_error_indicator <= 1'b0;
            host_error_indicator <= cond_s2[4];
            in_network_indicator <= cond_s2[3];
        end
    end

    // Status word seen in the host I/O status area; writing ones clears bits.
    logic [15:0] host_io_status_area;
    logic        any_ev;
    logic        st_clr;
    assign any_ev = ev_addr | ev_ctrl | ev_dup;
    assign st_clr = reg_wr && (reg_addr == REG_STATUS);

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            host_io_status_area <= STATUS_RST;
        end else begin
            for (int i = 0; i < 16; i++) begin
                if (st_clr && reg_wdata[i]) begin
                    host_io_status_area[i] <= 1'b0;
                end
            end
            if (ev_addr) begin
                host_io_status_area[ST_ADDR_BIT] <= 1'b1;
            end
            if (ev_ctrl) begin
                host_io_status_area[ST_CTRL_BIT] <= 1'b1;
            end
            if (ev_dup) begin
                host_io_status_area[ST_DUP_BIT] <= 1'b1;
            end
            if (any_ev) begin
                host_io_status_area[ST_LOG_BIT] <= 1'b1;
            end
        end
    end

    // Error log; codes are written in a fixed order when events coincide,
    // one per cycle, by holding pending bits.
    logic [15:0]       log_mem [LOG_DEPTH];
    logic [LOG_AW-1:0] log_count;
    logic [LOG_AW-1:0] log_index;
    logic [2:0]        pend;
    logic              log_we;
    logic [15:0]       log_code;
    logic              log_clr;

    always_comb begin
        log_we   = 1'b0;
        log_code = CODE_ADDR;
        if (pend[0]) begin
            log_we   = 1'b1;
            log_code = CODE_ADDR;
        end else if (pend[1]) begin
            log_we   = 1'b1;
            log_code = CODE_CTRL;
        end else if (pend[2]) begin
            log_we   = 1'b1;
            log_code = CODE_DUP;
        end
    end

    assign log_clr = reg_wr && (reg_addr == REG_LOG_CLEAR);

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pend <= 3'h0;
        end else begin
            pend[0] <= ev_addr | (pend[0] & ~log_we);
            pend[1] <= ev_ctrl | (pend[1] & ~(log_we & ~pend[0]));
            pend[2] <= ev_dup | (pend[2] & ~(log_we & ~pend[0] & ~pend[1]));
        end
    end

    // A full log drops new entries; the status bits still record the event.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            log_count <= '0;
        end else if (log_clr) begin
            log_count <= '0;
        end else if (log_we && (log_count < LOG_AW'(LOG_DEPTH))) begin
            log_mem[log_count] <= log_code;
            log_count          <= log_count + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            log_index <= '0;
        end else if (reg_wr && (reg_addr == REG_LOG_INDEX)) begin
            log_index <= reg_wdata[LOG_AW-1:0];
        end
    end

    // Interrupts.
    logic [2:0] irq_status;
    logic [2:0] irq_mask;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= (irq_status & ~((reg_wr && reg_addr == REG_IRQ_STATUS)
                          ? reg_wdata[2:0] : 3'h0)) | {ev_dup, ev_ctrl, ev_addr};
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            irq_mask <= IRQ_MASK_RST;
        end else if (reg_wr && (reg_addr == REG_IRQ_MASK)) begin
            irq_mask <= reg_wdata[2:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // Read port.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else if (reg_addr == REG_STATUS) begin
            reg_rdata <= host_io_status_area;
        end else if (reg_addr == REG_IRQ_STATUS) begin
            reg_rdata <= {13'h0000, irq_status};
        end else if (reg_addr == REG_IRQ_MASK) begin
            reg_rdata <= {13'h0000, irq_mask};
        end else if (reg_addr == REG_LOG_COUNT) begin
            reg_rdata <= {10'h000, log_count};
        end else if (reg_addr == REG_LOG_INDEX) begin
            reg_rdata <= {10'h000, log_index};
        end else if (reg_addr == REG_LOG_DATA) begin
            reg_rdata <= (log_index < log_count) ? log_mem[log_index] : 16'h0000;
        end else if (reg_addr == REG_NODE) begin
            reg_rdata <= {8'h00, addr_s2};
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Assertions.
    property p_normal;
        @(posedge mclk) disable iff (!nrst)
        (!err_addr && !err_ctrl && !err_dup)
            |=> run_indicator && !comm_error_indicator;
    endproperty
    a_normal: assert property (p_normal) else $error("normal indicators wrong");

    property p_addr;
        @(posedge mclk) disable iff (!nrst)
        err_addr |=> comm_error_indicator && !run_indicator;
    endproperty
    a_addr: assert property (p_addr) else $error("address error indicators wrong");

    property p_addr_status;
        @(posedge mclk) disable iff (!nrst)
        ev_addr |=> host_io_status_area[ST_ADDR_BIT] && host_io_status_area[ST_LOG_BIT];
    endproperty
    a_addr_status: assert property (p_addr_status) else $error("address bits not set");

    property p_ctrl;
        @(posedge mclk) disable iff (!nrst)
        ev_ctrl |=> host_io_status_area[ST_CTRL_BIT] && comm_error_indicator;
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("controller error not shown");

    property p_ctrl_log;
        @(posedge mclk) disable iff (!nrst)
        (pend == 3'b010) |-> log_code == CODE_CTRL;
    endproperty
    a_ctrl_log: assert property (p_ctrl_log) else $error("wrong controller code");

    property p_dup;
        @(posedge mclk) disable iff (!nrst)
        (err_dup && !err_addr && !err_ctrl)
            |=> run_indicator && comm_error_indicator && !in_network_indicator;
    endproperty
    a_dup: assert property (p_dup) else $error("duplicate pattern wrong");

    property p_miswire;
        @(posedge mclk) disable iff (!nrst)
        (cond_s2[2] && !err_addr && !err_ctrl) |=> !in_network_indicator;
    endproperty
    a_miswire: assert property (p_miswire) else $error("miswire pattern wrong");

    property p_log15;
        @(posedge mclk) disable iff (!nrst)
        any_ev |=> host_io_status_area[ST_LOG_BIT];
    endproperty
    a_log15: assert property (p_log15) else $error("bit 15 not set");

    property p_logcnt;
        @(posedge mclk) disable iff (!nrst)
        (log_we && !log_clr && log_count < LOG_AW'(LOG_DEPTH))
            |=> log_count == $past(log_count) + 1'b1;
    endproperty
    a_logcnt: assert property (p_logcnt) else $error("log count not advanced");

    c_addr: cover property (@(posedge mclk) disable iff (!nrst) ev_addr);
    c_dup:  cover property (@(posedge mclk) disable iff (!nrst) ev_dup ##1 irq);
    c_two:  cover property (@(posedge mclk) disable iff (!nrst) pend[0] && pend[1]);

endmodule : nnei_top

/* tb_nnei_top.sv */
// Self-checking testbench of the network node error indicator.
`timescale 1ns/100ps
module tb_nnei_top;
    import nnei_pkg::*;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  node_addr = 8'h05;
    logic        ctrl_fault = 1'b0;
    logic        dup_addr = 1'b0;
    logic        fiber_miswire = 1'b0;
    logic        in_network = 1'b1;
    logic        host_fault = 1'b0;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        run_ind, comm_ind, host_ind, innet_ind, irq;
    logic [15:0] rd;
    int          err_total = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #25 mclk = ~mclk;

    nnei_host i_host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    nnei_top i_dut (.mclk(mclk), .nrst(nrst), .node_addr(node_addr),
        .ctrl_fault(ctrl_fault), .dup_addr(dup_addr), .fiber_miswire(fiber_miswire),
        .in_network(in_network), .host_fault(host_fault), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .run_indicator(run_ind), .comm_error_indicator(comm_ind),
        .host_error_indicator(host_ind), .in_network_indicator(innet_ind), .irq(irq));

    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // Ceiling is far above the few hundred cycles the sequence needs.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total = err_total + 1;
            complete_run();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic rd_check(input logic [3:0] a, input logic [15:0] exp);
        i_host.read_reg(a, rd);
        check(rd, exp);
    endtask : rd_check

    // Inputs pass a two stage synchroniser, so six cycles cover the indicator delay.
    task automatic set_cond(input logic [7:0] a, input logic c, input logic d,
                            input logic m, input logic h);
        @(posedge mclk);
        node_addr     <= a;
        ctrl_fault    <= c;
        dup_addr      <= d;
        fiber_miswire <= m;
        host_fault    <= h;
        repeat (6) @(posedge mclk);
    endtask : set_cond

    function automatic logic [15:0] ind();
        return {12'h000, run_ind, comm_ind, host_ind, innet_ind};
    endfunction : ind

    task automatic clear_all;
        i_host.write_reg(REG_STATUS, 16'hffff);
        i_host.write_reg(REG_IRQ_STATUS, 16'h0007);
        i_host.write_reg(REG_LOG_CLEAR, 16'h0001);
    endtask : clear_all

    task automatic event_case(input logic [7:0] a, input logic c, input logic d,
                              input logic m, input logic [3:0] pat,
                              input logic [15:0] st, input logic [15:0] code,
                              input logic [15:0] ib);
        clear_all();
        set_cond(a, c, d, m, 1'b0);
        check(ind(), {12'h000, pat});
        rd_check(REG_STATUS, st);
        rd_check(REG_IRQ_STATUS, ib);
        check({15'h0000, irq}, 16'h0001);
        rd_check(REG_LOG_COUNT, 16'h0001);
        i_host.write_reg(REG_LOG_INDEX, 16'h0000);
        rd_check(REG_LOG_DATA, code);
        set_cond(8'h05, 1'b0, 1'b0, 1'b0, 1'b0);
    endtask : event_case

    initial begin
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        check(ind(), 16'h0000);
        rd_check(REG_STATUS, STATUS_RST);
        rd_check(REG_IRQ_MASK, {13'h0000, IRQ_MASK_RST});
        i_host.write_reg(REG_IRQ_MASK, 16'h0007);
        set_cond(8'h3e, 1'b0, 1'b0, 1'b0, 1'b0);
        check(ind(), 16'h0009);
        rd_check(REG_LOG_COUNT, 16'h0000);
        in_network <= 1'b0;
        set_cond(8'h3e, 1'b0, 1'b0, 1'b0, 1'b0);
        check(ind(), 16'h0008);
        in_network <= 1'b1;
        set_cond(8'h3e, 1'b0, 1'b0, 1'b0, 1'b1);
        check(ind(), 16'h000b);
        event_case(8'h3f, 1'b0, 1'b0, 1'b0, 4'h4, 16'h8100, CODE_ADDR, 16'h0001);
        event_case(8'h00, 1'b0, 1'b0, 1'b0, 4'h4, 16'h8100, CODE_ADDR, 16'h0001);
        event_case(8'h05, 1'b1, 1'b0, 1'b0, 4'h4, 16'h8002, CODE_CTRL, 16'h0002);
        event_case(8'h05, 1'b0, 1'b1, 1'b0, 4'hc, 16'h8200, CODE_DUP, 16'h0004);
        event_case(8'h05, 1'b0, 1'b0, 1'b1, 4'hc, 16'h8200, CODE_DUP, 16'h0004);
        check({15'h0000, irq}, 16'h0001);
        i_host.write_reg(REG_IRQ_MASK, 16'h0003);
        @(posedge mclk);
        check({15'h0000, irq}, 16'h0000);
        i_host.write_reg(REG_IRQ_MASK, 16'h0007);
        @(posedge mclk);
        check({15'h0000, irq}, 16'h0001);
        i_host.write_reg(REG_IRQ_STATUS, 16'h0004);
        @(posedge mclk);
        check({15'h0000, irq}, 16'h0000);
        i_host.write_reg(REG_LOG_INDEX, 16'h0001);
        rd_check(REG_LOG_INDEX, 16'h0001);
        rd_check(REG_LOG_DATA, 16'h0000);
        i_host.write_reg(4'hf, 16'h1234);
        rd_check(4'hf, 16'h0000);
        rd_check(REG_NODE, 16'h0005);
        check(ind(), 16'h0009);
        complete_run();
    end
endmodule : tb_nnei_top
